//--- hw/clvdf_pkg.sv
// constants shared by the core low-voltage detect flag logic
// assumes one 125 MHz system clock and an active-low asynchronous device reset
//
// What this block does
// - A strap tied high turns the core regulator on and tied low turns it off.
// - Detection, the flag and the level status work only while the regulator is on.
// - The flag, bit 2 of the second interrupt request register, sets when the core supply drops below about 2.45V.
// - The flag sets once per falling crossing; while the supply stays low it sets again only when the regulator is re-enabled or a reset ends.
// - Firmware clears the flag, and it sets again only after the supply rises and falls once more, or the regulator is re-enabled or a reset ends while it is low.
// - Any device reset forces the flag to zero even while the supply is low.
// - While the regulator is on, a read-only bit in the watchdog control register shows the live supply level.
// - The flag is offered to the interrupt system as a request source.
package clvdf_pkg;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned LVD_FLAG_BIT = 2;
    localparam int unsigned LVD_STATUS_BIT = 6;
    // ------------------------------------------------------------
    // reset values and synchroniser depth
    // ------------------------------------------------------------
    localparam logic RST_FLAG = 1'h0;
    localparam logic RST_SYNC = 1'h0;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam int unsigned SYNC_STAGES = 2;
endpackage

//--- hw/clvdf_sync.sv
// two-flop level synchroniser for the comparator output
// assumes the input may change at any time relative to the clock
`timescale 1ns/100ps
module clvdf_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_ff <= clvdf_pkg::RST_SYNC;
            sync_out <= clvdf_pkg::RST_SYNC;
        end else if (ce_in) begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

//--- hw/clvdf_top.sv
// flag and status logic of the core low-voltage detector
// assumes the comparator output is high while the core supply is below threshold,
// and that firmware clear arrives as a one-cycle pulse in the system clock domain
`timescale 1ns/100ps
module clvdf_top (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic regulator_enable_strap_in,
    input wire logic core_supply_low_in,
    input wire logic flag_clear_in,
    output logic low_voltage_flag_out,
    output logic core_voltage_level_status_out,
    output logic [7:0] peripheral_irq_request_reg2_out,
    output logic [7:0] watchdog_control_reg_out,
    output logic irq_request_out
);
    // ------------------------------------------------------------
    // synchronised comparator level
    // ------------------------------------------------------------
    logic low_sync;
    logic detect_on;
    logic fall_evt;
    logic nxt_flag;
    logic flag_ff;

    clvdf_sync u_sync (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .ce_in(clk_en_in),
        .async_in(core_supply_low_in),
        .sync_out(low_sync)
    );

    // strap high means regulator running; detector only works then
    assign detect_on = regulator_enable_strap_in;

    // ------------------------------------------------------------
    // arming tracker: where the supply stood at the last enabled edge
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_DISABLED,
        LVL_ABOVE,
        LVL_BELOW
    } clvdf_level_t;

    clvdf_level_t level_ff;
    clvdf_level_t nxt_level;

    // a disabled regulator parks the tracker, so enabling it with the
    // supply already low counts as a fresh falling crossing
    always_comb begin
        nxt_level = level_ff;
        case (level_ff)
            LVL_DISABLED: begin
                if (!detect_on) begin
                    nxt_level = LVL_DISABLED;
                end else if (low_sync) begin
                    nxt_level = LVL_BELOW;
                end else begin
                    nxt_level = LVL_ABOVE;
                end
            end
            LVL_ABOVE: begin
                if (!detect_on) begin
                    nxt_level = LVL_DISABLED;
                end else if (low_sync) begin
                    nxt_level = LVL_BELOW;
                end else begin
                    nxt_level = LVL_ABOVE;
                end
            end
            LVL_BELOW: begin
                // staying low keeps the tracker here, which is what stops a re-set
                if (!detect_on) begin
                    nxt_level = LVL_DISABLED;
                end else if (low_sync) begin
                    nxt_level = LVL_BELOW;
                end else begin
                    nxt_level = LVL_ABOVE;
                end
            end
            default: begin
                nxt_level = LVL_DISABLED;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_ff <= LVL_DISABLED;
        end else if (clk_en_in) begin
            level_ff <= nxt_level;
        end
    end

    // one event per rising of the low level, i.e. a falling supply crossing
    assign fall_evt = detect_on & low_sync & (level_ff != LVL_BELOW);

    // ------------------------------------------------------------
    // sticky flag: set wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        nxt_flag = flag_ff;
        if (flag_clear_in) begin
            nxt_flag = 1'h0;
        end
        if (fall_evt) begin
            nxt_flag = 1'h1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_ff <= clvdf_pkg::RST_FLAG;
        end else if (clk_en_in) begin
            flag_ff <= nxt_flag;
        end
    end

    // ------------------------------------------------------------
    // next values of the level status and the register images
    // ------------------------------------------------------------
    logic nxt_status;
    logic [7:0] nxt_irq_reg2;
    logic [7:0] nxt_wdt_reg;

    // status is forced low with the strap off, so a disabled regulator
    // never reports a stale low level
    assign nxt_status = low_sync & detect_on;

    // only the assigned bit of each image carries information; the
    // other bits keep their reset value so reads of them stay quiet
    for (genvar b = 0; b < 8; b++) begin : g_image_bits
        if (b == clvdf_pkg::LVD_FLAG_BIT) begin : g_flag_bit
            assign nxt_irq_reg2[b] = nxt_flag;
        end else begin : g_flag_pad
            assign nxt_irq_reg2[b] = clvdf_pkg::RST_REG[b];
        end
        if (b == clvdf_pkg::LVD_STATUS_BIT) begin : g_status_bit
            assign nxt_wdt_reg[b] = nxt_status;
        end else begin : g_status_pad
            assign nxt_wdt_reg[b] = clvdf_pkg::RST_REG[b];
        end
    end

    // ------------------------------------------------------------
    // flag output
    // ------------------------------------------------------------
    // registered from the same next value as the internal flag, so the
    // pin and the image never disagree by a cycle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_voltage_flag_out <= clvdf_pkg::RST_FLAG;
        end else if (clk_en_in) begin
            low_voltage_flag_out <= nxt_flag;
        end
    end

    // ------------------------------------------------------------
    // level status output
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_voltage_level_status_out <= clvdf_pkg::RST_SYNC;
        end else if (clk_en_in) begin
            core_voltage_level_status_out <= nxt_status;
        end
    end

    // ------------------------------------------------------------
    // interrupt request image
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            peripheral_irq_request_reg2_out <= clvdf_pkg::RST_REG;
        end else if (clk_en_in) begin
            peripheral_irq_request_reg2_out <= nxt_irq_reg2;
        end
    end

    // ------------------------------------------------------------
    // watchdog control image
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            watchdog_control_reg_out <= clvdf_pkg::RST_REG;
        end else if (clk_en_in) begin
            watchdog_control_reg_out <= nxt_wdt_reg;
        end
    end

    // ------------------------------------------------------------
    // interrupt request line
    // ------------------------------------------------------------
    // a level request: it stays up until firmware clears the flag,
    // so the interrupt system cannot miss it
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_request_out <= clvdf_pkg::RST_FLAG;
        end else if (clk_en_in) begin
            irq_request_out <= nxt_flag;
        end
    end
endmodule

//--- dv/clvdf_top_sva.sv
// port checker for the low-voltage flag block
// assumes one clock domain and a bind from the bench top
`timescale 1ns/100ps
module clvdf_chk (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic regulator_enable_strap_in,
    input wire logic core_supply_low_in,
    input wire logic flag_clear_in,
    input wire logic low_voltage_flag_out,
    input wire logic core_voltage_level_status_out,
    input wire logic [7:0] peripheral_irq_request_reg2_out,
    input wire logic [7:0] watchdog_control_reg_out,
    input wire logic irq_request_out
);
    wire logic f = low_voltage_flag_out, s = core_supply_low_in, g = regulator_enable_strap_in;
    wire logic on = g && clk_en_in, lo = s && on, st = core_voltage_level_status_out;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    chk_flag_sets: assert property ($rose(s) ##0 on [*3] |=> f) else $error("no set");
    chk_no_repeat: assert property (lo [*6] ##0 !f |=> !f) else $error("re-set");
    chk_clear_ok: assert property (lo [*6] ##0 flag_clear_in |=> !f) else $error("clr");
    chk_strap_gate: assert property (!g && !f |=> !f) else $error("strap");
    chk_status_live: assert property (on [*4] |=> st == $past(s, 3)) else $error("st");
    chk_reset_clear: assert property (disable iff (1'h0) !rstn_in |-> !f) else $error("rst");
    chk_flag_image: assert property (peripheral_irq_request_reg2_out == {5'h00, f, 2'h0})
        else $error("image");
    chk_irq_mirror: assert property (irq_request_out == f) else $error("irq");
    chk_status_image: assert property (watchdog_control_reg_out == {1'h0, st, 6'h00})
        else $error("status image");
endmodule

//--- dv/clvdf_top_test.sv
// self-checking bench for the low-voltage flag block
// assumes the checker module is compiled first; inputs change on falling edges
`timescale 1ns/100ps
module clvdf_top_test;
    logic clk = 1'h0, rstn = 1'h0, strap = 1'h1, low = 1'h0, clr = 1'h0, flag, st;
    logic [7:0] pir, wdt;
    logic ce = 1'h1, irq;
    int fails = 0, comparisons = 0;
    always #4 clk = ~clk;
    clvdf_top DUT (.core_clk_in(clk), .rstn_in(rstn), .clk_en_in(ce),
        .regulator_enable_strap_in(strap), .core_supply_low_in(low), .flag_clear_in(clr),
        .low_voltage_flag_out(flag), .core_voltage_level_status_out(st),
        .peripheral_irq_request_reg2_out(pir), .watchdog_control_reg_out(wdt),
        .irq_request_out(irq));
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic edge_set();
        low = 1'h1;
        tick(9);
        chk("peripheral_irq_request_reg2", pir, 8'h04);
        clr = 1'h1;
        tick(1);
        clr = 1'h0;
        chk("clear", flag, 8'h00);
    endtask
    task automatic rearm();
        low = 1'h0;
        tick(4);
        low = 1'h1;
        tick(2);
        chk("sync", st, 8'h00);
        tick(1);
        chk("rearm", {flag, st}, 8'h03);
        chk("wdt", wdt, 8'h40);
        chk("irq", irq, 8'h01);
    endtask
    task automatic strap_off();
        strap = 1'h0;
        clr = 1'h1;
        tick(1);
        clr = 1'h0;
        low = 1'h0;
        tick(3);
        low = 1'h1;
        tick(4);
        chk("off", {flag, st}, 8'h00);
    endtask
    task automatic reset_low();
        strap = 1'h1;
        tick(4);
        chk("strap on", flag, 8'h01);
        rstn = 1'h0;
        #1 chk("reset", flag, 8'h00);
        tick(2);
        ce = 1'h0;
        rstn = 1'h1;
        tick(4);
        chk("frozen", flag, 8'h00);
        ce = 1'h1;
        tick(2);
        chk("release", flag, 8'h00);
        tick(1);
        chk("reset set", flag, 8'h01);
        chk("reset irq", irq, 8'h01);
        chk("reset wdt", wdt, 8'h40);
    endtask
    initial begin
        tick(10);
        rstn = 1'h1;
        edge_set();
        rearm();
        strap_off();
        reset_low();
        conclude();
    end
endmodule
bind clvdf_top clvdf_chk u_chk (.*);
